// file: rtl/ebcsw_map.vh
// Register map, field layout and timing constants for ebcsw_top
// ===========================================================
// Operation
// - Split field picks boundary 1000/4000/8000/C000; upper select at or above it.
// - Upper region always reaches the top of the address map.
// - Internal accesses beat both external select regions.
// - Wait strobe stays idle on internal cycles; lower select too unless visibility is set.
// - Enabled select is active for every external or visible cycle inside its region.
// - Reset leaves both selects on internal waits, count three.
// - Upper region cycles insert 0 to 3 waits from its field.
// - Lower region under internal control inserts 0 to 3 waits.
// - Upper region never takes its wait count from the data bus.
// - Lower wait source bit: 1 data bus, 0 software field.
// - Device releases the data bus during the fourth phase.
// - External source latches D2:0 at end of fourth phase, 0 to 7.
// - Data bus wait value is latched only with lower select asserted.
// - Strobe mode: 0 off, 1 gated fourth phase, 2/3 plain phase.
// - Gated strobe is active low, ignores lower select polarity.
// - External waits stop the low noise freeze of D2:0 only.
// - Mode bit set selects low noise, clear high performance.
// - Visibility bit shows internal cycles on strobes and selects.
// - Each select has enable and polarity; polarity 1 is high.
// - Wait output stalls the processor, idle for internal cycles.
`ifndef EBCSW_MAP_VH
`define EBCSW_MAP_VH

// ===========================================================
// Register offsets and reset values
`define EBCSW_OFF_BIC      12'h000
`define EBCSW_OFF_CSC      12'h004
`define EBCSW_OFF_STAT     12'h008
`define EBCSW_BIC_RESET    8'h00
`define EBCSW_CSC_RESET    8'h33

// ===========================================================
// Field positions
`define EBCSW_BIC_VIS      0
`define EBCSW_BIC_MODE     1
`define EBCSW_BIC_WSRC     2
`define EBCSW_BIC_STRB_LO  3
`define EBCSW_BIC_STRB_HI  4
`define EBCSW_BIC_SPLIT_LO 5
`define EBCSW_BIC_SPLIT_HI 6
`define EBCSW_CSC_LWS_LO   0
`define EBCSW_CSC_LWS_HI   1
`define EBCSW_CSC_LEN      2
`define EBCSW_CSC_LPOL     3
`define EBCSW_CSC_UWS_LO   4
`define EBCSW_CSC_UWS_HI   5
`define EBCSW_CSC_UEN      6
`define EBCSW_CSC_UPOL     7

// ===========================================================
// Region boundaries, strobe modes and phase timing
`define EBCSW_BND0         16'h1000
`define EBCSW_BND1         16'h4000
`define EBCSW_BND2         16'h8000
`define EBCSW_BND3         16'hC000
`define EBCSW_STRB_OFF     2'h0
`define EBCSW_STRB_GATED   2'h1
`define EBCSW_T4_LAST      2'h2

`endif

// file: rtl/ebcsw_top.v
// Chip select decode and wait state generator with APB registers
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "ebcsw_map.vh"

module ebcsw_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        cpu_req,
  input  wire [15:0] cpu_addr,
  input  wire        cpu_write,
  input  wire [7:0]  cpu_wdata,
  input  wire        cpu_internal,
  output reg  [7:0]  cpu_rdata,
  output reg         cpu_done,
  output reg         wait_request_out,
  output reg         memory_request_stall_n,
  output reg  [15:0] ext_addr,
  output reg  [7:0]  data_out,
  output reg  [7:0]  data_oe,
  input  wire [7:0]  data_in,
  output reg         read_strobe_n,
  output reg         write_strobe_n,
  output reg         lower_region_select,
  output reg         upper_region_select,
  output reg         wait_strobe_pin,
  output reg         wait_strobe_oe
);

  // ===========================================================
  // States
  localparam ST_IDLE = 3'h0;
  localparam ST_T1   = 3'h1;
  localparam ST_T2   = 3'h2;
  localparam ST_T3   = 3'h3;
  localparam ST_T4   = 3'h4;
  localparam ST_WAIT = 3'h5;
  localparam ST_DONE = 3'h6;

  // ===========================================================
  // Functions
  function in_upper;
    input [15:0] a;
    input [1:0]  s;
    reg   [15:0] b;
    begin
      case (s)
        2'h0:    b = `EBCSW_BND0;
        2'h1:    b = `EBCSW_BND1;
        2'h2:    b = `EBCSW_BND2;
        default: b = `EBCSW_BND3;
      endcase
      in_upper = (a >= b);
    end
  endfunction

  function pin_level;
    input act;
    input pol;
    begin
      pin_level = pol ? act : ~act;
    end
  endfunction

  // ===========================================================
  // Registers and fields
  reg  [7:0]  bic;
  reg  [7:0]  csc;
  wire        vis       = bic[`EBCSW_BIC_VIS];
  wire        low_noise = bic[`EBCSW_BIC_MODE];
  wire        wsrc_ext  = bic[`EBCSW_BIC_WSRC];
  wire [1:0]  strb_mode = bic[`EBCSW_BIC_STRB_HI:`EBCSW_BIC_STRB_LO];
  wire [1:0]  split     = bic[`EBCSW_BIC_SPLIT_HI:`EBCSW_BIC_SPLIT_LO];
  wire [1:0]  lower_ws  = csc[`EBCSW_CSC_LWS_HI:`EBCSW_CSC_LWS_LO];
  wire [1:0]  upper_ws  = csc[`EBCSW_CSC_UWS_HI:`EBCSW_CSC_UWS_LO];
  wire        lower_en  = csc[`EBCSW_CSC_LEN];
  wire        lower_pol = csc[`EBCSW_CSC_LPOL];
  wire        upper_en  = csc[`EBCSW_CSC_UEN];
  wire        upper_pol = csc[`EBCSW_CSC_UPOL];

  // ===========================================================
  // Bus cycle state
  reg  [2:0]  state;
  reg  [1:0]  sub;
  reg  [2:0]  wcnt;
  reg  [15:0] cur_addr;
  reg         cur_write;
  reg  [7:0]  cur_wdata;
  reg         cur_ext;
  reg         cur_upper;
  reg         cur_show;
  reg  [2:0]  last_waits;
  reg         last_src;
  reg         held;
  reg  [7:0]  din_meta;
  reg  [7:0]  din_sync;
  reg  [2:0]  next_state;
  reg  [1:0]  next_sub;
  reg  [2:0]  next_wcnt;
  reg  [2:0]  waits;
  reg         src_bus;
  reg  [31:0] next_rdata;
  reg         next_err;
  reg  [7:0]  next_oe;

  // ===========================================================
  // APB slave
  // Zero wait slave: read data is formed in the setup cycle
  wire apb_setup = psel & ~penable;
  wire apb_wr    = psel & penable & pready & pwrite;
  wire hit_bic   = (paddr == `EBCSW_OFF_BIC);
  wire hit_csc   = (paddr == `EBCSW_OFF_CSC);
  wire hit_stat  = (paddr == `EBCSW_OFF_STAT);

  always @* begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (hit_bic) begin
      next_rdata = {24'h00_0000, bic};
    end else if (hit_csc) begin
      next_rdata = {24'h00_0000, csc};
    end else if (hit_stat) begin
      next_rdata = {24'h00_0000, (state != ST_IDLE), 3'h0,
                    last_src, last_waits};
      next_err   = pwrite;
    end else begin
      next_err   = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_setup;
      if (apb_setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
        pslverr <= next_err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bic <= `EBCSW_BIC_RESET;
      csc <= `EBCSW_CSC_RESET;
    end else if (apb_wr) begin
      if (hit_bic) begin
        bic <= pwdata[7:0];
      end else if (hit_csc) begin
        csc <= pwdata[7:0];
      end
    end
  end

  // ===========================================================
  // Data bus synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_meta <= 8'h00;
      din_sync <= 8'h00;
    end else begin
      din_meta <= data_in;
      din_sync <= din_meta;
    end
  end

  // ===========================================================
  // Decode of the cycle being started or in progress
  wire accept  = (state == ST_IDLE) & cpu_req;
  wire a_ext   = accept ? ~cpu_internal : cur_ext;
  wire a_upper = accept ? in_upper(cpu_addr, split) : cur_upper;
  wire a_write = accept ? cpu_write : cur_write;
  wire a_show  = accept ? (~cpu_internal | vis) : cur_show;

  // ===========================================================
  // Wait count chosen at the end of the fourth phase
  always @* begin
    src_bus = cur_ext & ~cur_upper & lower_en & wsrc_ext;
    if (!cur_ext) begin
      waits = 3'h0;
    end else if (cur_upper) begin
      waits = {1'b0, upper_ws};
    end else if (src_bus) begin
      waits = din_sync[2:0];
    end else begin
      waits = {1'b0, lower_ws};
    end
  end

  // ===========================================================
  // Cycle sequencer
  // Fourth phase spans three clocks so the synchronised bus is
  // valid when the wait count is taken
  always @* begin
    next_state = state;
    next_sub   = sub;
    next_wcnt  = wcnt;
    case (state)
      ST_IDLE: begin
        if (cpu_req) begin
          next_state = ST_T1;
        end
      end
      ST_T1: begin
        next_state = ST_T2;
      end
      ST_T2: begin
        next_state = ST_T3;
      end
      ST_T3: begin
        next_state = ST_T4;
        next_sub   = 2'h0;
      end
      ST_T4: begin
        if (sub == `EBCSW_T4_LAST) begin
          if (waits == 3'h0) begin
            next_state = ST_DONE;
          end else begin
            next_state = ST_WAIT;
            next_wcnt  = waits - 3'h1;
          end
        end else begin
          next_sub = sub + 2'h1;
        end
      end
      ST_WAIT: begin
        if (wcnt == 3'h0) begin
          next_state = ST_DONE;
        end else begin
          next_wcnt = wcnt - 3'h1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      sub        <= 2'h0;
      wcnt       <= 3'h0;
      cur_addr   <= 16'h0000;
      cur_write  <= 1'b0;
      cur_wdata  <= 8'h00;
      cur_ext    <= 1'b0;
      cur_upper  <= 1'b0;
      cur_show   <= 1'b0;
      last_waits <= 3'h0;
      last_src   <= 1'b0;
      held       <= 1'b0;
    end else begin
      state <= next_state;
      sub   <= next_sub;
      wcnt  <= next_wcnt;
      if (accept) begin
        cur_addr  <= cpu_addr;
        cur_write <= cpu_write;
        cur_wdata <= cpu_wdata;
        cur_ext   <= a_ext;
        cur_upper <= a_upper;
        cur_show  <= a_show;
      end
      if (state == ST_T4 && sub == `EBCSW_T4_LAST) begin
        last_waits <= waits;
        last_src   <= src_bus;
      end
      if (state == ST_DONE && cur_show) begin
        held <= cur_write;
      end
    end
  end

  // ===========================================================
  // Pin timing, taken from the next state so pins are flops
  wire in_cyc = (next_state != ST_IDLE) & (next_state != ST_DONE);
  wire strobe = in_cyc & (next_state != ST_T1);
  wire t4_now = (next_state == ST_T4);
  wire t4_strb = t4_now & (next_sub == 2'h0);
  wire wphase = strobe & ~t4_now;
  wire lsel   = in_cyc & a_show & ~a_upper & lower_en;
  wire usel   = in_cyc & a_show & a_upper & upper_en;
  wire g_strb = t4_strb & a_ext & ~a_upper & lower_en;
  wire u_strb = t4_strb & a_ext;
  wire drv    = wphase & a_show & a_write;
  wire between = (next_state == ST_IDLE);

  // Freeze keeps the last write on the bus to cut RF noise;
  // bits 2:0 are freed so outside wait logic can drive them
  always @* begin
    next_oe = 8'h00;
    if (drv) begin
      next_oe = 8'hFF;
    end else if (between && low_noise && held) begin
      next_oe = wsrc_ext ? 8'hF8 : 8'hFF;
    end
    if (t4_now) begin
      next_oe = 8'h00;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_addr            <= 16'h0000;
      data_out            <= 8'h00;
      data_oe             <= 8'h00;
      read_strobe_n       <= 1'b1;
      write_strobe_n      <= 1'b1;
      lower_region_select <= 1'b1;
      upper_region_select <= 1'b1;
      wait_strobe_pin     <= 1'b1;
      wait_strobe_oe      <= 1'b0;
    end else begin
      // Low noise holds the address between external or visible cycles
      if (accept && (a_show || !low_noise)) begin
        ext_addr <= cpu_addr;
      end
      if (drv) begin
        data_out <= cur_write & ~accept ? cur_wdata : cpu_wdata;
      end
      data_oe             <= next_oe;
      read_strobe_n       <= ~(strobe & a_show & ~a_write);
      write_strobe_n      <= ~(strobe & a_show & a_write);
      lower_region_select <= pin_level(lsel, lower_pol);
      upper_region_select <= pin_level(usel, upper_pol);
      case (strb_mode)
        `EBCSW_STRB_OFF: begin
          wait_strobe_pin <= 1'b1;
          wait_strobe_oe  <= 1'b0;
        end
        `EBCSW_STRB_GATED: begin
          wait_strobe_pin <= ~g_strb;
          wait_strobe_oe  <= 1'b1;
        end
        default: begin
          wait_strobe_pin <= ~u_strb;
          wait_strobe_oe  <= 1'b1;
        end
      endcase
    end
  end

  // ===========================================================
  // Processor side
  // Stall only in wait states, internal cycles never wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_rdata              <= 8'h00;
      cpu_done               <= 1'b0;
      wait_request_out       <= 1'b0;
      memory_request_stall_n <= 1'b1;
    end else begin
      cpu_done               <= (next_state == ST_DONE);
      wait_request_out       <= (next_state == ST_WAIT);
      memory_request_stall_n <= ~(next_state == ST_WAIT);
      if (next_state == ST_DONE && cur_ext && !cur_write) begin
        cpu_rdata <= din_sync;
      end
    end
  end

endmodule

// file: tb/ebcsw_ext_dev.sv
// Model of an external device on the parallel data bus
`timescale 1ns/100ps
module ebcsw_ext_dev (
  input  wire        pclk,
  input  wire        read_strobe_n,
  input  wire        wait_strobe_pin,
  input  wire        wait_strobe_oe,
  input  wire [15:0] ext_addr,
  input  wire [2:0]  wait_code,
  output wire [7:0]  data_in
);
// ===========================================================
// Released lines toggle so stale data never looks valid
reg  [7:0] junk = 8'hA5;
wire       strobe_on = wait_strobe_oe && !wait_strobe_pin;
always @(posedge pclk) begin
  junk <= ~junk;
end
// Wait code only while the strobe is low, read data while read strobe
assign data_in = strobe_on ? {junk[7:3], wait_code} :
                 !read_strobe_n ? (ext_addr[7:0] ^ 8'h5A) : junk;
endmodule

// file: tb/ebcsw_sva.sv
// Assertion checker for the select decode and wait generator
`timescale 1ns/100ps
module ebcsw_sva (
  input wire       pclk,
  input wire       presetn,
  input wire       cpu_req,
  input wire       cpu_internal,
  input wire       cpu_done,
  input wire       wait_request_out,
  input wire       memory_request_stall_n,
  input wire [7:0] data_oe,
  input wire       wait_strobe_pin,
  input wire       wait_strobe_oe
);
// ===========================================================
// Cycle tracking
reg       busy;
reg       intl;
reg [4:0] cnt;
wire      acc = cpu_req && !busy && !cpu_done;
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    busy <= 1'b0;
    intl <= 1'b0;
    cnt  <= 5'h0;
  end else begin
    busy <= acc ? 1'b1 : (cpu_done ? 1'b0 : busy);
    intl <= acc ? cpu_internal : intl;
    cnt  <= acc ? 5'h1 : (busy ? cnt + 5'h1 : cnt);
  end
end
// ===========================================================
// Properties
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
done_window_a: assert property (
  acc |-> ##[7:14] cpu_done) else $error("cycle end too late");
done_early_a: assert property (
  acc |-> ##1 !cpu_done [*6]) else $error("cycle end too early");
internal_fast_a: assert property (
  acc && cpu_internal |-> ##7 cpu_done) else $error("internal waited");
internal_quiet_a: assert property (
  acc && cpu_internal |=>
  (!wait_request_out && (wait_strobe_pin || !wait_strobe_oe)) [*8])
  else $error("internal cycle not quiet");
stall_inverse_a: assert property (
  memory_request_stall_n == !wait_request_out) else $error("stall level");
wait_end_a: assert property (
  $fell(wait_request_out) |-> cpu_done) else $error("wait end");
wait_span_a: assert property (
  wait_request_out |-> busy && !intl && cnt >= 5'h7)
  else $error("wait out of place");
bus_release_a: assert property (
  busy && !intl && cnt >= 5'h4 && cnt <= 5'h6 |-> data_oe == 8'h00)
  else $error("data bus driven in fourth phase");
strobe_phase_a: assert property (
  wait_strobe_oe && !wait_strobe_pin |-> busy && !intl && cnt == 5'h4)
  else $error("strobe outside fourth phase");
endmodule
bind ebcsw_top ebcsw_sva u_sva (
  .pclk(pclk), .presetn(presetn), .cpu_req(cpu_req),
  .cpu_internal(cpu_internal), .cpu_done(cpu_done),
  .wait_request_out(wait_request_out),
  .memory_request_stall_n(memory_request_stall_n), .data_oe(data_oe),
  .wait_strobe_pin(wait_strobe_pin), .wait_strobe_oe(wait_strobe_oe)
);

// file: tb/testbench.sv
// Self-checking bench for the select decode and wait generator
`timescale 1ns/100ps
module testbench;
reg         pclk, presetn, psel, penable, pwrite;
reg  [11:0] paddr;
reg  [31:0] pwdata;
wire [31:0] prdata;
wire        pready, pslverr, cpu_done, wait_request_out;
reg         cpu_req, cpu_write, cpu_internal;
reg  [15:0] cpu_addr;
reg  [7:0]  cpu_wdata;
wire [7:0]  cpu_rdata, data_out, data_oe, data_in;
wire [15:0] ext_addr;
wire        memory_request_stall_n, read_strobe_n, write_strobe_n;
wire        lower_region_select, upper_region_select;
wire        wait_strobe_pin, wait_strobe_oe;
reg  [2:0]  wcode;
reg  [7:0]  ctl, csc, q, wd;
reg  [15:0] a, lastad, ew;
reg  [31:0] seed, r;
reg         e, il, wr, u, lo, up, st, ws, rs;
integer     failures, cmp_count, ticks, n, nw, i;
ebcsw_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_write(cpu_write),
  .cpu_wdata(cpu_wdata), .cpu_internal(cpu_internal),
  .cpu_rdata(cpu_rdata), .cpu_done(cpu_done),
  .wait_request_out(wait_request_out),
  .memory_request_stall_n(memory_request_stall_n), .ext_addr(ext_addr),
  .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
  .lower_region_select(lower_region_select),
  .upper_region_select(upper_region_select),
  .wait_strobe_pin(wait_strobe_pin), .wait_strobe_oe(wait_strobe_oe));
ebcsw_ext_dev u_dev (.pclk(pclk), .read_strobe_n(read_strobe_n),
  .wait_strobe_pin(wait_strobe_pin), .wait_strobe_oe(wait_strobe_oe),
  .ext_addr(ext_addr), .wait_code(wcode), .data_in(data_in));
// ===========================================================
// Helpers
function [31:0] rnd();
  begin
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  end
endfunction
function [15:0] bnd(input [1:0] s);
  bnd = s == 2'h0 ? 16'h1000 : s == 2'h1 ? 16'h4000 :
        s == 2'h2 ? 16'h8000 : 16'hC000;
endfunction
// Upper field, data bus code or lower field, none when internal
function [15:0] exp_n(input [15:0] ad, input in);
  exp_n = in ? 16'h7 : 16'h7 + ((ad >= bnd(ctl[6:5])) ? csc[5:4] :
          (ctl[2] && csc[2]) ? wcode : csc[1:0]);
endfunction
task check(input string nm, input [15:0] ev, input [15:0] sv);
  begin
    cmp_count = cmp_count + 1;
    if (sv !== ev) begin
      failures = failures + 1;
      $display("ERROR %s expected %h seen %h", nm, ev, sv);
    end
  end
endtask
task apb(input w, input [11:0] ad, input [7:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
endtask
task run(input [15:0] ad, input in, input w);
  begin
    @(posedge pclk);
    cpu_req <= 1'b1;
    cpu_addr <= ad;
    cpu_internal <= in;
    cpu_write <= w;
    cpu_wdata <= ad[15:8];
    @(posedge pclk);
    cpu_req <= 1'b0;
    n = 0;
    nw = 0;
    {lo, up, st, ws, rs} = 5'h00;
    while (cpu_done !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n = n + 1;
      if (wait_request_out === 1'b1) nw = nw + 1;
      lo = lo | (lower_region_select === csc[3]);
      up = up | (upper_region_select === csc[7]);
      st = st | (wait_strobe_oe === 1'b1 && wait_strobe_pin === 1'b0);
      ws = ws | (write_strobe_n === 1'b0);
      rs = rs | (read_strobe_n === 1'b0);
      if (write_strobe_n === 1'b0) wd = data_out;
    end
  end
endtask
task results;
  begin
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
endtask
// ===========================================================
// Clock, timeout and sequence
initial begin
  pclk = 1'b0;
  forever #4 pclk = ~pclk;
end
always @(posedge pclk) begin
  ticks = ticks + 1;
  if (ticks == 20000) begin
    failures = failures + 1;
    $display("ERROR timeout expected finish seen hang");
    results;
  end
end
initial begin
  {presetn, psel, penable, pwrite, cpu_req, cpu_write} = 6'h0;
  {cpu_internal, paddr, pwdata, cpu_addr, cpu_wdata} = 0;
  {failures, cmp_count, ticks} = 0;
  seed = 32'h0000_003A;
  wcode = 3'h0;
  ctl = 8'h00;
  csc = 8'h33;
  wd = 8'h00;
  repeat (4) @(posedge pclk);
  presetn <= 1'b1;
  apb(1'b0, 12'h004, 8'h00);
  check("select control", 16'h0033, {8'h00, q});
  apb(1'b0, 12'h00C, 8'h00);
  check("unmapped error", 16'h0001, {15'h0, e});
  run(16'h8000, 1'b0, 1'b0);
  check("reset upper waits", 16'h000A, n[15:0]);
  run(16'h0100, 1'b0, 1'b1);
  check("reset lower waits", 16'h000A, n[15:0]);
  lastad = 16'h0100;
  $display("reset tests done");
  for (i = 0; i < 48; i = i + 1) begin
    r = rnd();
    ctl = r[7:0] & 8'h7F;
    if (ctl[2] && ctl[4:3] == 2'h0) ctl[3] = 1'b1;
    csc = r[15:8];
    if (ctl[4:3] == 2'h1) csc[2] = 1'b1;
    wcode = r[18:16];
    il = (r[21:19] == 3'h0);
    r = rnd();
    a = r[15:0];
    if (il) a[15:12] = 4'h0;
    wr = r[16];
    u = (a >= bnd(ctl[6:5]));
    // Zero wait reads share the bus with the strobe clock
    if (!wr && !il && exp_n(a, il) == 16'h0007 &&
        (ctl[4] || (ctl[3] && !u))) wr = 1'b1;
    apb(1'b1, 12'h000, ctl);
    apb(1'b1, 12'h004, csc);
    run(a, il, wr);
    check("cycle length", exp_n(a, il), n[15:0]);
    check("wait states", exp_n(a, il) - 16'h7, nw[15:0]);
    check("wait strobe", {15'h0, !il && (ctl[4] || (ctl[3] && !u))},
          {15'h0, st});
    check("lower select", {15'h0, (!il || ctl[0]) && csc[2] && !u},
          {15'h0, lo});
    check("upper select", {15'h0, (!il || ctl[0]) && csc[6] && u},
          {15'h0, up});
    if (!il || ctl[0] || !ctl[1]) lastad = a;
    check("address hold", lastad, ext_addr);
    check("strobes", {14'h0, (!il || ctl[0]) && wr, (!il || ctl[0]) && !wr},
          {14'h0, ws, rs});
    if ((!il || ctl[0]) && wr)
      check("write data", {8'h00, a[15:8]}, {8'h00, wd});
    ew = exp_n(a, il) - 16'h0007;
    apb(1'b0, 12'h008, 8'h00);
    check("wait status", {12'h000, !il && !u && ctl[2] && csc[2], ew[2:0]},
          {8'h00, q});
    if (!il && !wr)
      check("read data", {8'h00, a[7:0] ^ 8'h5A},
            {8'h00, cpu_rdata});
    $display("test %0d done", i);
  end
  results;
end
endmodule
